//--- hw/pbs_pkg.sv
// Purpose: shared constants and carrier types for the pipelined burst SRAM access block
// Assumes: 18-bit words, two byte lanes of eight data bits plus one parity bit each
// Notes: the word address is 18 bits wide, the low two bits feed the burst counter
package pbs_pkg;
   // ==========================================================
   // Sizes
   localparam int ADDR_W = 18;
   localparam int WORD_W = 18;
   localparam int DATA_W = 16;
   localparam int LANES = 2;
   localparam int BURST_W = 2;
   // ==========================================================
   // Sleep timing: two clock cycles each way
   localparam int SLEEP_ENTRY_CYCLES = 2;
   localparam int SLEEP_RECOVERY_CYCLES = 2;
   // ==========================================================
   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
   localparam logic [WORD_W-1:0] WORD_RESET = 18'h00000;

   // Access kind held between clock rises
   typedef enum logic [1:0] {
      PBS_IDLE,
      PBS_READ,
      PBS_WRITE_PEND,
      PBS_WRITE
   } pbs_access_t;

   // Synchronous control inputs, as sampled together
   typedef struct packed {
      logic proc_strobe_n;
      logic ctrl_strobe_n;
      logic advance_n;
      logic global_write_n;
      logic byte_write_enable_n;
      logic [LANES-1:0] lane_n;
      logic sel_a_n;
      logic sel_b;
      logic sel_c_n;
   } pbs_ctrl_t;
endpackage

//--- hw/pbs_burst_counter.sv
// Purpose: two-bit wraparound burst address generator
// Assumes: linear_mode is static during operation
// Notes: keeps the start value and a beat count so both orders come out exactly
`timescale 1ns/1ps
module pbs_burst_counter (
   input wire logic clk, // System clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic load, // Start of an access
   input wire logic [1:0] start, // Low address bits at start
   input wire logic step, // Advance one beat
   input wire logic linear_mode, // 1 linear, 0 interleaved
   output logic [1:0] low_addr // Current low address bits
);
   logic [1:0] base;
   logic [1:0] beat;
   logic [1:0] next_base;
   logic [1:0] next_beat;

   // ==========================================================
   // Next state: load wins over step; step wraps after four beats
   always_comb begin
      next_base = base;
      next_beat = beat;
      if (load) begin
         next_base = start;
         next_beat = 2'h0;
      end else if (step) begin
         next_beat = beat + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         base <= 2'h0;
         beat <= 2'h0;
      end else begin
         base <= next_base;
         beat <= next_beat;
      end
   end

   // Order: linear adds the beat, interleaved XORs it
   assign low_addr = linear_mode ? base + beat : base ^ beat;
endmodule

//--- hw/pbs_sram_access.sv
// Contract
// - Inputs captured and read data output through registers on rising clock.
// - Read starts on a strobe with chip selected and both write inputs high.
// - Processor strobe is ignored while the first chip select is high.
// - Read data appears after the clock rise following the address latch.
// - First read cycle after deselect keeps outputs off regardless of output enable.
// - Deselect by chip selects plus a strobe turns outputs off at once.
// - Processor-strobe access ignores write and advance inputs in its first cycle.
// - Processor-strobe write completes at the second rise, global or byte write.
// - Byte write stores only lanes whose select is low.
// - Global write overrides byte controls and writes all bytes.
// - Data and parity pins float in any write cycle.
// - Controller-strobe write completes in one cycle and ignores advance.
// - Two-bit burst counter loads the low address bits at access start.
// - Advance low steps the burst counter for reads and writes; the code ignores advance in the PBS_WRITE_PEND cycle.
// - Interleaved order is start XOR beat index.
// - Linear order is start plus beat modulo four.
// - Sleep input enters and leaves low power in two cycles, data kept.
// - Access pending at sleep entry is dropped as invalid.
// - Both strobes low: only the processor strobe acts.
// - Order select low gives linear, high gives interleaved, static; the code takes linear_order high as linear.
// - Selected only with first and third selects low, second high.
//
// Purpose: access logic of a pipelined common-I/O burst SRAM, 256K words of 18 bits
// Assumes: output enable and sleep are asynchronous pins, synchronised here
// Notes: pad drive is split into out, enable; pad enable is low while driving
`timescale 1ns/1ps
module pbs_sram_access (
   input wire logic clk, // System clock, 10 MHz
   input wire logic rst_b, // Asynchronous reset, active low
   input wire pbs_pkg::pbs_ctrl_t ctrl, // Synchronous control pins
   input wire logic [pbs_pkg::ADDR_W-1:0] addr, // Address pins
   input wire logic [pbs_pkg::WORD_W-1:0] data_in, // Data and parity pad inputs
   input wire logic output_enable_n, // Asynchronous output enable
   input wire logic sleep_request, // Asynchronous sleep request
   input wire logic linear_order, // Burst order strap, 1 linear
   output logic [pbs_pkg::WORD_W-1:0] data_out, // Data and parity pad drive
   output logic data_oe_n, // Pad enable, low while driving
   output logic asleep // Low-power state reached
);
   localparam int DEPTH = 1 << pbs_pkg::ADDR_W;

   // ==========================================================
   // Input registers and synchronisers
   pbs_pkg::pbs_ctrl_t ctrl_q;
   logic [pbs_pkg::ADDR_W-1:0] addr_q;
   logic [pbs_pkg::WORD_W-1:0] din_q;
   logic oe_meta, oe_n_s;
   logic zz_meta, zz_s;

   // Synchronous inputs all pass an input register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= '1;
         addr_q <= pbs_pkg::ADDR_RESET;
         din_q <= pbs_pkg::WORD_RESET;
      end else begin
         ctrl_q <= ctrl;
         addr_q <= addr;
         din_q <= data_in;
      end
   end

   // Asynchronous pins: two flops before anything reads them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oe_meta <= 1'b1;
         oe_n_s <= 1'b1;
         zz_meta <= 1'b0;
         zz_s <= 1'b0;
      end else begin
         oe_meta <= output_enable_n;
         oe_n_s <= oe_meta;
         zz_meta <= sleep_request;
         zz_s <= zz_meta;
      end
   end

   // Strap caught after reset release; it must stay static anyway
   logic linear_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         linear_q <= 1'b0;
      end else begin
         linear_q <= linear_order;
      end
   end

   // ==========================================================
   // Cycle decode on the registered inputs
   logic selected, proc_go, ctrl_go, deselect, write_req, byte_any;
   logic [pbs_pkg::LANES-1:0] lanes_req;

   always_comb begin
      selected = !ctrl_q.sel_a_n && ctrl_q.sel_b && !ctrl_q.sel_c_n;
      // Processor strobe needs the first select low; it wins over controller strobe
      proc_go = !ctrl_q.proc_strobe_n && !ctrl_q.sel_a_n;
      ctrl_go = !proc_go && !ctrl_q.ctrl_strobe_n;
      deselect = (proc_go || ctrl_go) && !selected;
      // Global write overrides every byte control
      if (!ctrl_q.global_write_n) begin
         lanes_req = '1;
      end else if (!ctrl_q.byte_write_enable_n) begin
         lanes_req = ~ctrl_q.lane_n;
      end else begin
         lanes_req = '0;
      end
      byte_any = |lanes_req;
      write_req = byte_any;
   end

   // ==========================================================
   // Access state
   pbs_pkg::pbs_access_t state, next_state;
   logic sleeping, next_sleeping;
   logic [1:0] zz_cnt, next_zz_cnt;
   logic burst_load, burst_step;
   logic [1:0] low_addr;
   logic [pbs_pkg::ADDR_W-1:0] word_addr;
   logic [pbs_pkg::ADDR_W-3:0] base_addr, next_base_addr;
   logic first_read, next_first_read;

   always_comb begin
      next_state = state;
      next_base_addr = base_addr;
      next_first_read = 1'b0;
      burst_load = 1'b0;
      burst_step = 1'b0;
      next_sleeping = sleeping;
      next_zz_cnt = zz_cnt;
      // Sleep entry and exit each count two cycles
      if (zz_s != sleeping) begin
         if (zz_cnt == 2'(pbs_pkg::SLEEP_ENTRY_CYCLES - 1)) begin
            next_sleeping = zz_s;
            next_zz_cnt = 2'h0;
         end else begin
            next_zz_cnt = zz_cnt + 2'h1;
         end
      end else begin
         next_zz_cnt = 2'h0;
      end
      if (zz_s || sleeping) begin
         next_state = pbs_pkg::PBS_IDLE;
      end else if (deselect) begin
         next_state = pbs_pkg::PBS_IDLE;
      end else if ((proc_go || ctrl_go) && selected) begin
         burst_load = 1'b1;
         next_base_addr = addr_q[pbs_pkg::ADDR_W-1:2];
         if (proc_go) begin
            // Write inputs only judged at the next rise
            next_state = pbs_pkg::PBS_WRITE_PEND;
            next_first_read = (state == pbs_pkg::PBS_IDLE);
         end else if (write_req) begin
            next_state = pbs_pkg::PBS_WRITE;
         end else begin
            next_state = pbs_pkg::PBS_READ;
            next_first_read = (state == pbs_pkg::PBS_IDLE);
         end
      end else if (state != pbs_pkg::PBS_IDLE) begin
         // Continue or suspend: advance steps except in PBS_WRITE_PEND, otherwise hold
         burst_step = !ctrl_q.advance_n && state != pbs_pkg::PBS_WRITE_PEND;
         if (state == pbs_pkg::PBS_WRITE_PEND) begin
            next_state = write_req ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
         end else begin
            next_state = write_req ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= pbs_pkg::PBS_IDLE;
         base_addr <= '0;
         first_read <= 1'b0;
         sleeping <= 1'b0;
         zz_cnt <= 2'h0;
      end else begin
         state <= next_state;
         base_addr <= next_base_addr;
         first_read <= next_first_read;
         sleeping <= next_sleeping;
         zz_cnt <= next_zz_cnt;
      end
   end

   pbs_burst_counter u_burst (
      .clk(clk),
      .rst_b(rst_b),
      .load(burst_load),
      .start(addr_q[1:0]),
      .step(burst_step),
      .linear_mode(linear_q),
      .low_addr(low_addr)
   );

   // ==========================================================
   // Memory array, written per lane
   logic [pbs_pkg::WORD_W-1:0] mem [DEPTH];
   logic do_write;
   logic [pbs_pkg::WORD_W-1:0] rd_word;

   // The write lands one edge after do_write, at word_addr as it stands in the next cycle
   assign word_addr = {base_addr, low_addr};
   assign do_write = !sleeping && !zz_s && !deselect &&
                     (state == pbs_pkg::PBS_WRITE_PEND || state == pbs_pkg::PBS_WRITE ||
                      state == pbs_pkg::PBS_READ) && !proc_go && !ctrl_go && byte_any;

   // Controller-strobe write stores in its own cycle at the fresh address
   logic [pbs_pkg::ADDR_W-1:0] c_addr;
   logic c_write;
   assign c_addr = addr_q;
   assign c_write = ctrl_go && selected && write_req && !zz_s && !sleeping;

   // Burst writes land one edge late, so a beat that advanced stores at the next address
   logic wr_pend;
   logic [pbs_pkg::LANES-1:0] wr_lanes;
   logic [pbs_pkg::WORD_W-1:0] wr_data;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_pend <= 1'b0;
         wr_lanes <= '0;
         wr_data <= pbs_pkg::WORD_RESET;
      end else begin
         wr_pend <= do_write;
         wr_lanes <= lanes_req;
         wr_data <= din_q;
      end
   end

   // Lane 0 is data[7:0] with parity[16], lane 1 data[15:8] with parity[17]
   // One process owns the array; a fresh controller write comes last and so wins
   always_ff @(posedge clk) begin
      if (wr_pend && wr_lanes[0]) begin
         mem[word_addr][7:0] <= wr_data[7:0];
         mem[word_addr][16] <= wr_data[16];
      end
      if (wr_pend && wr_lanes[1]) begin
         mem[word_addr][15:8] <= wr_data[15:8];
         mem[word_addr][17] <= wr_data[17];
      end
      if (c_write && lanes_req[0]) begin
         mem[c_addr][7:0] <= din_q[7:0];
         mem[c_addr][16] <= din_q[16];
      end
      if (c_write && lanes_req[1]) begin
         mem[c_addr][15:8] <= din_q[15:8];
         mem[c_addr][17] <= din_q[17];
      end
   end

   assign rd_word = mem[word_addr];

   // ==========================================================
   // Output registers and pad enable
   logic [pbs_pkg::WORD_W-1:0] next_data_out;
   logic next_oe_n, next_asleep, writing;

   always_comb begin
      writing = do_write || c_write || write_req;
      next_data_out = data_out;
      if (next_state == pbs_pkg::PBS_READ || next_state == pbs_pkg::PBS_WRITE_PEND) begin
         next_data_out = rd_word;
      end
      // Pads float on deselect, write, sleep, first read after deselect
      if (deselect || writing || next_first_read || first_read || zz_s || sleeping) begin
         next_oe_n = 1'b1;
      end else if (state == pbs_pkg::PBS_READ || state == pbs_pkg::PBS_WRITE_PEND) begin
         next_oe_n = oe_n_s;
      end else begin
         next_oe_n = 1'b1;
      end
      next_asleep = next_sleeping;
   end

   // Read data and enable leave through output registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_out <= pbs_pkg::WORD_RESET;
         data_oe_n <= 1'b1;
         asleep <= 1'b0;
      end else begin
         data_out <= next_data_out;
         data_oe_n <= next_oe_n;
         asleep <= next_asleep;
      end
   end
endmodule

//--- verif/pbs_sram_access_chk.sv
// Purpose: port-level assertions for the pipelined burst SRAM access block
// Assumes: pins sampled at edge N show at the pads after edge N+2
// Notes: output enable is synchronised, so its effect is checked with slack
`timescale 1ns/1ps
module pbs_sram_access_chk (
   input wire logic clk, // System clock
   input wire logic rst_b, // Reset, active low
   input wire pbs_pkg::pbs_ctrl_t ctrl, // Control pins
   input wire logic output_enable_n, // Output enable pin
   input wire logic sleep_request, // Sleep pin
   input wire logic data_oe_n, // Pad enable, low while driving
   input wire logic asleep // Low-power flag
);
   // ==========================================
   // Access decode as seen at the pins
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   logic sel_ok;
   // Chip select pattern of a selected device
   assign sel_ok = !ctrl.sel_a_n && ctrl.sel_b && !ctrl.sel_c_n;
   sequence s_strobe;
      !ctrl.ctrl_strobe_n || (!ctrl.proc_strobe_n && !ctrl.sel_a_n);
   endsequence
   sequence s_read;
      s_strobe ##0 (sel_ok && ctrl.global_write_n && ctrl.byte_write_enable_n);
   endsequence
   sequence s_desel;
      s_strobe ##0 !sel_ok;
   endsequence
   sequence s_cwr;
      !ctrl.ctrl_strobe_n && ctrl.proc_strobe_n && sel_ok && !ctrl.global_write_n;
   endsequence
   // Quiet cycles keep the running read going, no sleep involved
   sequence s_quiet;
      ctrl.proc_strobe_n && ctrl.ctrl_strobe_n && !output_enable_n && !sleep_request &&
         ctrl.global_write_n && ctrl.byte_write_enable_n;
   endsequence
   sequence s_cont;
      s_quiet ##0 !ctrl.advance_n;
   endsequence
   a_oe_off_float: assert property (output_enable_n [*4] |=> data_oe_n)
      else $error("pads driven with output enable high");
   a_first_read_masked: assert property (s_desel ##1 s_read |-> ##3 data_oe_n)
      else $error("first read after deselect not masked");
   a_burst_beat_drives: assert property ((!output_enable_n) [*3] ##0 s_read ##1 s_cont
      ##1 s_quiet [*2] |-> ##1 !data_oe_n) else $error("second burst beat not driven");
   a_desel_float: assert property (s_desel |-> ##2 data_oe_n)
      else $error("pads driven after deselect");
   a_write_float: assert property (s_cwr |-> ##2 data_oe_n)
      else $error("pads driven in a write cycle");
   a_sleep_enter: assert property (sleep_request [*8] |-> asleep)
      else $error("low-power state not reached");
   a_sleep_exit: assert property ((!sleep_request) [*8] |-> !asleep)
      else $error("low-power state not left");
   a_sleep_float: assert property (asleep |-> data_oe_n)
      else $error("pads driven while asleep");
endmodule

bind pbs_sram_access pbs_sram_access_chk i_chk (.clk(clk), .rst_b(rst_b), .ctrl(ctrl),
   .output_enable_n(output_enable_n), .sleep_request(sleep_request), .data_oe_n(data_oe_n),
   .asleep(asleep));

//--- verif/pbs_host_model.sv
// Purpose: bus master model driving the SRAM access pins one cycle at a time
// Assumes: each operation is picked by a small code indexing a pin table
// Notes: released data lines toggle so a stale value never passes for data
`timescale 1ns/1ps
module pbs_host_model (
   input wire logic clk, // System clock
   output pbs_pkg::pbs_ctrl_t ctrl, // Control pins
   output logic [17:0] addr, // Address pins
   output logic [17:0] data, // Write data and parity
   output logic oe_n, // Output enable, active low
   output logic sleep // Sleep request
);
   // ==========================================
   // Pin patterns per operation code
   localparam logic [9:0] KIND [11] = '{10'h3fa, 10'h37a, 10'h2fa, 10'h29a, 10'h33a, 10'h13a,
      10'h3d2, 10'h2f8, 10'h0ba, 10'h1fe, 10'h3fd};
   localparam logic [10:0] DRV = 11'h158; // Codes that drive data
   localparam logic [10:0] OFF = 11'h578; // Codes with output enable high
   // Idle, deselected and released from time zero
   initial begin
      ctrl = KIND[10];
      addr = 18'h00000;
      data = 18'h00000;
      oe_n = 1'b1;
      sleep = 1'b0;
   end
   // One pin cycle, changed just after the rising edge
   task automatic op(input logic [3:0] k, input logic [17:0] a, input logic [17:0] d);
      @(posedge clk);
      ctrl <= KIND[k];
      addr <= a;
      data <= DRV[k] ? d : ~data;
      oe_n <= OFF[k];
   endtask
   // Sleep level, then deselected cycles with both strobes high
   task automatic nap(input logic lvl, input int n);
      sleep <= lvl;
      repeat (n) op(4'ha, 18'h00000, 18'h00000);
   endtask
endmodule

//--- verif/testbench.sv
// Purpose: self-checking bench for the pipelined burst SRAM access block
// Assumes: a read shows its word three edges after its strobe cycle
// Notes: the memory has no reset, so only written words are compared
`timescale 1ns/1ps
module testbench;
   // ==========================================
   // Signals, expected words and counters
   localparam logic [17:0] BASE = 18'h00100;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic linear_order = 1'b0;
   pbs_pkg::pbs_ctrl_t ctrl;
   logic [17:0] addr, data_in, data_out;
   logic oe_n, sleep, data_oe_n, asleep;
   logic [17:0] mem [4];
   int num_errors = 0;
   int compares = 0;
   // Free-running 10 MHz clock
   initial forever #50 clk = ~clk;
   pbs_host_model i_host (.clk(clk), .ctrl(ctrl), .addr(addr), .data(data_in), .oe_n(oe_n),
      .sleep(sleep));
   pbs_sram_access i_dut (.clk(clk), .rst_b(rst_b), .ctrl(ctrl), .addr(addr), .data_in(data_in),
      .output_enable_n(oe_n), .sleep_request(sleep), .linear_order(linear_order),
      .data_out(data_out), .data_oe_n(data_oe_n), .asleep(asleep));
   // Compare and count; an unknown bit matches only an unknown expected bit
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Controller-strobe read held in suspend until the word shows
   task automatic rd(input logic [1:0] w);
      i_host.op(4'h2, {BASE[17:2], w}, 18'h00000);
      repeat (3) i_host.op(4'h0, {BASE[17:2], w}, 18'h00000);
      #1;
      check(data_out, mem[w]);
   endtask
   // Burst write from start 00, then every word read back
   task automatic t_write_burst;
      for (int i = 0; i < 4; i++) begin
         mem[i] = 18'h3c3c0 + 18'(i);
         i_host.op(i == 0 ? 4'h3 : 4'h4, BASE, mem[i]);
      end
      for (int i = 0; i < 4; i++) rd(2'(i));
      $display("test write_burst done");
   endtask
   // Read bursts from every nonzero start, both orders, each from deselect
   task automatic t_read_bursts;
      logic [1:0] j;
      for (int lin = 0; lin < 2; lin++) begin
         for (int s = 1; s < 4; s++) begin
            i_host.op(4'h7, BASE, 18'h00000);
            linear_order <= 1'(lin);
            for (int k = 0; k < 7; k++) begin
               i_host.op(k == 0 ? 4'h2 : (k < 4 ? 4'h1 : 4'h0), BASE + 18'(s), 18'h00000);
               j = 2'(k - 3);
               #1;
               if (k >= 3) check(data_out, mem[lin == 1 ? 2'(s) + j : 2'(s) ^ j]);
               if (k >= 3) check({17'h0, data_oe_n}, {17'h0, j == 2'h0});
            end
         end
      end
      linear_order <= 1'b0;
      $display("test read_bursts done");
   endtask
   // Processor write: write inputs in the strobe cycle must be ignored
   task automatic t_byte_write;
      i_host.op(4'h5, BASE + 18'h1, 18'h00000);
      i_host.op(4'h6, BASE + 18'h1, 18'h00a5a);
      mem[1] = {mem[1][17], 1'b0, mem[1][15:8], 8'h5a};
      i_host.op(4'h0, BASE + 18'h1, 18'h00000);
      rd(2'h1);
      $display("test byte_write done");
   endtask
   // Both strobes low, then a processor strobe with select one high
   task automatic t_refused;
      i_host.op(4'h8, BASE + 18'h3, ~mem[3]);
      i_host.op(4'h0, BASE + 18'h3, 18'h00000);
      rd(2'h3);
      rd(2'h0);
      i_host.op(4'h9, BASE + 18'h2, 18'h00000);
      repeat (3) i_host.op(4'h0, BASE + 18'h2, 18'h00000);
      #1;
      check(data_out, mem[0]);
      check({17'h0, data_oe_n}, 18'h00000);
      $display("test refused done");
   endtask
   // Sleep entry and exit; stored word 1 must survive
   task automatic t_sleep;
      i_host.op(4'h7, BASE, 18'h00000);
      i_host.nap(1'b1, 10);
      #1;
      check({17'h0, asleep}, 18'h00001);
      i_host.nap(1'b0, 10);
      #1;
      check({17'h0, asleep}, 18'h00000);
      rd(2'h1);
      $display("test sleep done");
   endtask
   // Counts and verdict, the only place the run ends
   task automatic summarize;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Reset for four cycles, then the scenarios in turn
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_write_burst;
      t_read_bursts;
      t_byte_write;
      t_refused;
      t_sleep;
      summarize;
   end
endmodule
